// [lvds_display_serializer.sv]
`timescale 1ns/10ps
// Behaviour
// - 21-bit word spread over three data channels
// - Capture one whole word every input clock
// - Forward phase-locked clock on fourth channel
// - Seven bits per channel per clock period
// - Static select picks rising or falling capture
// - Missing input clock drives all pairs low
// - No ordering needed between clock and power-down
// - Input clock runs from 18 to 68 MHz; all seven slots fit only in periods of 7 or more system clocks (35 ns)
// - Spread-spectrum input clock keeps serializing correctly
// - Power-down low puts all drivers high-impedance
// - Seven slots equally spaced over the period
module lvds_display_serializer #(
  parameter int FIFO_DEPTH = 2,
  parameter int FIFO_AW    = 1
) (
  // Clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 sys_rst_i,
  // Parallel side pins
  input  wire logic                                 parallel_input_clock_i,
  input  wire logic [lvds_ser_pkg::WORD_W-1:0]      parallel_input_bits_i,
  input  wire logic                                 edge_rise_sel_i,
  input  wire logic                                 power_down_n_i,
  // Serial side pins
  output logic      [lvds_ser_pkg::CHAN_N-1:0]      serial_data_o,
  output logic                                      forwarded_serial_clock_o,
  output logic      [lvds_ser_pkg::CHAN_N:0]        pair_oe_n_o,
  // Buffer status
  output logic                                      buffer_ready_o
);
  import lvds_ser_pkg::*;

  // Synchronisers for all pins
  logic [1:0]        pclk_sync_ff;        // Input clock, two stages
  logic [1:0]        pd_sync_ff;          // Power-down, two stages
  logic [1:0]        esel_sync_ff;        // Edge select, two stages
  logic [WORD_W-1:0] din_meta_ff;         // Data, first stage
  logic [WORD_W-1:0] din_sync_ff;         // Data, second stage
  logic              pclk_prev_ff;        // Last synced clock level

  // Same depth on clock and data keeps their alignment
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pclk_sync_ff <= 2'h0;
      pd_sync_ff   <= 2'h0;
      esel_sync_ff <= 2'h0;
      din_meta_ff  <= '0;
      din_sync_ff  <= '0;
      pclk_prev_ff <= 1'b0;
    end
    else
    begin
      pclk_sync_ff <= {pclk_sync_ff[0], parallel_input_clock_i};
      pd_sync_ff   <= {pd_sync_ff[0], power_down_n_i};
      esel_sync_ff <= {esel_sync_ff[0], edge_rise_sel_i};
      din_meta_ff  <= parallel_input_bits_i;
      din_sync_ff  <= din_meta_ff;
      pclk_prev_ff <= pclk_sync_ff[1];
    end
  end

  // Edge decode
  wire pclk_s    = pclk_sync_ff[1];
  wire pd_on     = pd_sync_ff[1];         // High = not powered down
  wire rise_sel  = esel_sync_ff[1];
  wire edge_seen = pclk_s != pclk_prev_ff;
  wire cap_evt   = edge_seen && (pclk_s == rise_sel) && pd_on;

  // Loss detector and period measurement
  logic [CNT_W-1:0] idle_cnt_ff;          // Cycles since any clock edge
  logic [CNT_W-1:0] per_cnt_ff;           // Cycles since last capture
  logic [CNT_W-1:0] period_ff;            // Last measured period
  link_state_t      st_ff;
  link_state_t      nxt_st;

  wire clk_lost = idle_cnt_ff == LOSS_CNT;
  wire [CNT_W-1:0] per_now = (per_cnt_ff == LOSS_CNT) ? LOSS_CNT : per_cnt_ff + 6'h01;

  // Period is remeasured each cycle of the input clock, so slow drift
  // from spread spectrum is followed frame by frame
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      idle_cnt_ff <= 6'h00;
      per_cnt_ff  <= 6'h00;
      period_ff   <= 6'h00;
    end
    else
    begin
      idle_cnt_ff <= edge_seen ? 6'h00 : (clk_lost ? LOSS_CNT : idle_cnt_ff + 6'h01);
      per_cnt_ff  <= cap_evt ? 6'h00 : per_now;
      if (cap_evt)
        period_ff <= per_now;
    end
  end

  // Link state: any ordering of power-down and clock arrival ends in run
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_OFF:  nxt_st = ST_LOST;
      ST_LOST: nxt_st = cap_evt ? ST_ARM : ST_LOST;
      ST_ARM:  nxt_st = cap_evt ? ST_RUN : ST_ARM;
      ST_RUN:  nxt_st = ST_RUN;
      default: nxt_st = ST_OFF;
    endcase
    if (!pd_on)
      nxt_st = ST_OFF;
    else if (clk_lost)
      nxt_st = ST_LOST;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      st_ff <= ST_OFF;
    else
      st_ff <= nxt_st;
  end

  // Two-entry word buffer between capture and serializer
  logic [WORD_W-1:0]  fifo_mem [0:FIFO_DEPTH-1];
  logic [FIFO_AW-1:0] wr_ptr_ff;
  logic [FIFO_AW-1:0] rd_ptr_ff;
  logic [FIFO_AW:0]   count_ff;
  logic [WORD_W-1:0]  cur_word_ff;        // Word now on the wire

  wire running   = st_ff == ST_RUN;
  wire frame_go  = cap_evt && (st_ff == ST_ARM || running);
  wire fifo_full = count_ff == (FIFO_AW + 1)'(FIFO_DEPTH);
  wire fifo_emp  = count_ff == '0;
  wire push      = cap_evt && !fifo_full; // Full buffer refuses the word
  wire pop       = frame_go && !fifo_emp;

  // Pop at each frame start; a stalled frame start lets the buffer fill
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !pd_on)
    begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      count_ff    <= '0;
      cur_word_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        fifo_mem[wr_ptr_ff] <= din_sync_ff;
        wr_ptr_ff           <= wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        cur_word_ff <= fifo_mem[rd_ptr_ff];
        rd_ptr_ff   <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (FIFO_AW + 1)'(push) - (FIFO_AW + 1)'(pop);
    end
  end

  // Slot timer: add 7 per cycle, step a slot per period's worth
  logic [SLOT_W-1:0] slot_ff;
  logic [ACC_W-1:0]  acc_ff;
  wire  [ACC_W-1:0]  acc_sum  = acc_ff + ACC_W'(SLOT_STEP);
  wire               slot_adv = running && !frame_go && (slot_ff != LAST_SLOT)
                                && (acc_sum >= {1'b0, period_ff});

  // Frame restarts at each capture; bit 6 absorbs the rounding
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !running || frame_go)
    begin
      slot_ff <= 3'h0;
      acc_ff  <= '0;
    end
    else
    begin
      slot_ff <= slot_adv ? slot_ff + 3'h1 : slot_ff;
      acc_ff  <= slot_adv ? acc_sum - {1'b0, period_ff} : acc_sum;
    end
  end

  // Per-channel bit pick through the single mapping table
  logic [CHAN_N-1:0] ser_bit;
  genvar c;
  generate
    for (c = 0; c < CHAN_N; c++)
    begin : g_chan
      assign ser_bit[c] = cur_word_ff[BIT_MAP[c * SLOT_N + int'(slot_ff)]];
    end
  endgenerate

  wire fwd_bit = FWD_CLK_PATTERN[slot_ff];
  // Power-down must silence the pairs at once, before the state leaves run
  wire drive_on = running && pd_on;

  // Output registers; only a running link drives non-zero data and clock levels
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      serial_data_o            <= '0;
      forwarded_serial_clock_o <= 1'b0;
      pair_oe_n_o              <= '1;
      buffer_ready_o           <= 1'b0;
    end
    else
    begin
      serial_data_o            <= drive_on ? ser_bit : '0;
      forwarded_serial_clock_o <= drive_on ? fwd_bit : 1'b0;
      pair_oe_n_o              <= {(CHAN_N + 1){!pd_on}};
      buffer_ready_o           <= !fifo_full;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_pd_hiz;
    !pd_on |=> (pair_oe_n_o == '1) && (serial_data_o == '0) && !forwarded_serial_clock_o;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("drivers on in power-down");

  property p_lost_low;
    (pd_on && clk_lost) |=> ##1 (serial_data_o == '0) && !forwarded_serial_clock_o;
  endproperty
  a_lost_low: assert property (p_lost_low) else $error("pairs not low on clock loss");

  property p_push;
    (push && !pop) |=> count_ff == $past(count_ff) + 1'b1;
  endproperty
  a_push: assert property (p_push) else $error("captured word not stored");

  property p_slot_range;
    slot_ff <= LAST_SLOT;
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("slot past six");

  property p_frame_start;
    frame_go |=> (slot_ff == 3'h0) && (acc_ff == '0);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame not restarted");

  property p_fwd_clk;
    (running && pd_on && !clk_lost) |=> forwarded_serial_clock_o == FWD_CLK_PATTERN[$past(slot_ff)];
  endproperty
  a_fwd_clk: assert property (p_fwd_clk) else $error("forwarded clock wrong");

  property p_map_ch0;
    (running && pd_on && !clk_lost) |=>
      serial_data_o[0] == $past(cur_word_ff[BIT_MAP[int'(slot_ff)]]);
  endproperty
  a_map_ch0: assert property (p_map_ch0) else $error("channel 0 bit wrong");

  property p_edge_sel;
    cap_evt == (pd_on && (rise_sel ? $rose(pclk_s) : $fell(pclk_s)));
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("capture on wrong edge");

  property p_lost_time;
    $rose(clk_lost) |-> $past(idle_cnt_ff) == LOSS_CNT - 6'h01;
  endproperty
  a_lost_time: assert property (p_lost_time) else $error("loss flagged early");

  c_run:      cover property (st_ff == ST_ARM ##1 st_ff == ST_RUN);
  c_full:     cover property (fifo_full);
  c_lost:     cover property (running ##1 clk_lost);
  c_all_slot: cover property (running && slot_ff == LAST_SLOT);
endmodule // lvds_display_serializer

// [lvds_ser_pkg.sv]
package lvds_ser_pkg;
  // Word and link geometry
  localparam int WORD_W = 21;
  localparam int CHAN_N = 3;
  localparam int SLOT_N = 7;
  localparam int SLOT_W = 3;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 3'h6;
  localparam logic [SLOT_W-1:0] SLOT_STEP = 3'h7;

  // Forwarded clock level per slot, slot 0 in bit 0
  localparam logic [SLOT_N-1:0] FWD_CLK_PATTERN = 7'h63;

  // Input bit index for channel c, slot s at entry c*SLOT_N+s
  localparam logic [4:0] BIT_MAP [0:WORD_W-1] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
    5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
    5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};

  // Timing: system clock and input clock loss timeout
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLK_LOSS_NS = 200;
  localparam int CLK_LOSS_CYCLES = (CLK_LOSS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] LOSS_CNT = CNT_W'(CLK_LOSS_CYCLES);
  localparam int ACC_W = CNT_W + 1;

  // Link state, Gray coded along off -> lost -> arm -> run
  typedef enum logic [1:0] {
    ST_OFF  = 2'h0,
    ST_LOST = 2'h1,
    ST_ARM  = 2'h3,
    ST_RUN  = 2'h2
  } link_state_t;
endpackage

// [lvds_rx_model.sv]
`timescale 1ns/10ps
// Display link receiver, sampling the serial side in the system clock domain
module lvds_rx_model
  import lvds_ser_pkg::*;
(
  // Clock
  input  wire logic                                 clk_i,
  // Serial side
  input  wire logic [lvds_ser_pkg::CHAN_N-1:0]      serial_data_i,
  input  wire logic                                 fwd_clk_i,
  // Recovered slots 1, 2, 4, 5 of each channel, low run of the clock
  output logic      [lvds_ser_pkg::WORD_W-1:0]      word_o,
  output logic      [3:0]                           low_run_o
);
  logic                fclk_ff;              // Clock seen one cycle ago
  logic [CHAN_N-1:0]   data_ff;              // Data seen one cycle ago
  logic [WORD_W-1:0]   acc_ff = '0;          // Slots collected so far
  logic [WORD_W-1:0]   nxt_acc;              // Slots with this cycle merged
  logic [3:0]          run_ff = '0;          // Cycles of low clock
  wire                 fell = fclk_ff & ~fwd_clk_i;  // Slot 2 begins
  wire                 rose = ~fclk_ff & fwd_clk_i;  // Slot 5 begins

  // Slot edges only show at clock transitions, so slots 0, 3, 6 stay unseen
  always_comb
  begin
    nxt_acc = acc_ff;
    for (int c = 0; c < CHAN_N; c++)
    begin
      if (fell)
      begin
        nxt_acc[c*SLOT_N+1] = data_ff[c];
        nxt_acc[c*SLOT_N+2] = serial_data_i[c];
      end
      if (rose)
      begin
        nxt_acc[c*SLOT_N+4] = data_ff[c];
        nxt_acc[c*SLOT_N+5] = serial_data_i[c];
      end
    end
  end

  // Word handed out at each rise, low run measured for slot spacing
  always_ff @(posedge clk_i)
  begin
    fclk_ff <= fwd_clk_i;
    data_ff <= serial_data_i;
    acc_ff  <= nxt_acc;
    run_ff  <= fell ? 4'h1 : (~fwd_clk_i ? run_ff + 4'h1 : run_ff);
    if (rose)
    begin
      word_o    <= nxt_acc;
      low_run_o <= run_ff;
    end
  end
endmodule // lvds_rx_model

// [lvds_display_serializer_bench.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module lvds_display_serializer_bench;
  import lvds_ser_pkg::*;
  typedef struct packed { logic sel; logic [WORD_W-1:0] a; logic [WORD_W-1:0] e; } row_t;
  logic clk_i = 0, sys_rst_i = 1, pclk = 0, pclk_run = 1, sel = 1, pdn_n = 0;
  logic [WORD_W-1:0] pins = '0, cur_a = '0, cur_b = '0, rx_word;
  logic [CHAN_N-1:0] serial_data_o;
  logic [CHAN_N:0]   pair_oe_n_o;
  logic              fwd_o, buffer_ready_o;
  logic [3:0]        low_run;
  int n_errors = 0, checks_done = 0, cycles = 0, half = 24;
  // Rows: capture select, word around the rising edge, bits seen in slots 1, 2, 4, 5
  row_t rows [0:4] = '{'{1'b1, 21'h15_5555, 21'h05_1114}, '{1'b0, 21'h15_5555, 21'h08_8a22},
    '{1'b1, 21'h1f_c07f, 21'h0d_8036}, '{1'b0, 21'h00_3f80, 21'h0d_8036},
    '{1'b1, 21'h0a_aaaa, 21'h08_8a22}};

  lvds_display_serializer i_lvds_display_serializer (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .parallel_input_clock_i(pclk), .parallel_input_bits_i(pins), .edge_rise_sel_i(sel),
    .power_down_n_i(pdn_n), .serial_data_o(serial_data_o), .forwarded_serial_clock_o(fwd_o),
    .pair_oe_n_o(pair_oe_n_o), .buffer_ready_o(buffer_ready_o));
  lvds_rx_model i_lvds_rx_model (.clk_i(clk_i), .serial_data_i(serial_data_o),
    .fwd_clk_i(fwd_o), .word_o(rx_word), .low_run_o(low_run));

  // System clock and a free pixel clock that can be stopped
  always #2.5 clk_i = ~clk_i;
  always
  begin
    #(half);
    if (pclk_run) pclk = ~pclk;
  end
  // Word A straddles the rising edge, its inverse B the falling edge
  always @(pclk)
  begin
    #12;
    pins = pclk ? cur_b : cur_a;
  end
  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // Drive pins, let about fifteen input periods pass, then look at the link
  task automatic run_word(input logic s, input logic [WORD_W-1:0] a,
                          input logic [WORD_W-1:0] e);
    @(posedge clk_i) #1;
    sel = s;
    cur_a = a;
    cur_b = ~a;
    repeat (150) @(posedge clk_i);
    #1;
    `CHK("rx_word", e, rx_word)
    `CHK("low_run", 1'b1, (low_run >= 4'h3 && low_run <= 4'h5))
    `CHK("oe_run", 4'h0, pair_oe_n_o)
    `CHK("buf_ready", 1'b1, buffer_ready_o)
  endtask

  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    #1;
    `CHK("oe_reset", 4'hf, pair_oe_n_o)
    `CHK("data_reset", 3'h0, serial_data_o)
    `CHK("buf_reset", 1'b0, buffer_ready_o)
    sys_rst_i = 0;
    // Pixel clock runs long before power-down is released
    repeat (300) @(posedge clk_i);
    #1 pdn_n = 1;
    foreach (rows[i]) run_word(rows[i].sel, rows[i].a, rows[i].e);
    // Slower clock near the low end of the range
    half = 25;
    run_word(1'b1, 21'h1f_c07f, 21'h0d_8036);
    half = 24;
    // Power down for longer than the minimum pulse
    @(posedge clk_i) #1 pdn_n = 0;
    repeat (220) @(posedge clk_i);
    #1;
    `CHK("oe_pd", 4'hf, pair_oe_n_o)
    pdn_n = 1;
    run_word(1'b0, 21'h0a_aaaa, 21'h05_1114);
    // Missing clock drives every pair low while enabled
    pclk_run = 0;
    repeat (60) @(posedge clk_i);
    #1;
    `CHK("loss_data", 3'h0, serial_data_o)
    `CHK("loss_fwd", 1'b0, fwd_o)
    `CHK("loss_oe", 4'h0, pair_oe_n_o)
    pclk_run = 1;
    run_word(1'b1, 21'h15_5555, 21'h05_1114);
    end_sim();
  end
endmodule // lvds_display_serializer_bench
